// *** verilog/isvm_vector_map.v ***
/*
 * Interrupt source to vector map: request flags, request masks and
 * source levels behind an APB slave, arbitration of pending sources and
 * the latched winning vector presented to the CPU core.
 * Assumes source events are one-cycle pulses from logic on mclk; any
 * pin edge detection sits upstream.
 */
// Our own choices: the placing of the registers and the APB interface to the registers.
// Overview of operation
// - External request zero: vector 8, IRQ 0
// - Lowest IRQ wins among equal levels
// - Table address is base plus twice IRQ
// - Sixteen sources per flag and mask register
// - Four 3-bit level fields per register
// - Vector number equals IRQ plus eight
// - Transfer channels at IRQ 4, 14, 24, 36
// - Serial port errors at IRQ 65, 66
// - Pulse generators at IRQ 94 to 96
// - Sensor link sources at IRQ 182 to 185
// - Flash fault at IRQ 186, own level
// - Network sources only on network variants
// - Flags sticky until software clears; mask gates
// - Eight levels used for arbitration
// - Winner vector and level latched, readable
// - Fixed order within one level
`timescale 1ns/1ps
`default_nettype none
`include "isvm_consts.vh"

module isvm_vector_map #(
  parameter HAS_NETWORK = 1,
  parameter NUM_SRC     = 192
) (
  input  wire                   mclk,
  input  wire                   rstn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire [NUM_SRC-1:0]     srcEvent,
  output reg                    cpuRequest_r,
  output reg  [7:0]             cpuVector_r,
  output reg  [3:0]             cpuLevel_r,
  output reg  [23:0]            cpuTableAddr_r,
  output reg                    irqOut_r
);

  localparam FLAG_W  = `ISVM_NUM_FLAG_REGS * 16;
  localparam LEVEL_W = `ISVM_NUM_LEVEL_REGS * 16;

  // network sources dropped on other variants
  wire [NUM_SRC-1:0] implMask = (HAS_NETWORK != 0) ? `ISVM_IMPL_MASK :
                                (`ISVM_IMPL_MASK & ~`ISVM_NET_MASK);

  reg  [FLAG_W-1:0]  flag_r;      // request_flag_reg words
  reg  [FLAG_W-1:0]  flagNxt;
  reg  [FLAG_W-1:0]  mask_r;      // request_mask_reg words
  reg  [FLAG_W-1:0]  maskNxt;
  reg  [LEVEL_W-1:0] level_r;     // source_level_reg words
  reg  [LEVEL_W-1:0] levelNxt;
  reg  [16:0]        vstat_r;     // winning_vector_status
  reg  [1:0]         istat_r;     // Block event status
  reg  [1:0]         istatNxt;
  reg  [1:0]         ien_r;       // Block event enables
  reg  [31:0]        rdNxt;       // Read data next
  reg                errNxt;      // Unmapped access

  wire [LEVEL_W-1:0] levelWmask;  // Writable level bits
  wire [NUM_SRC*3-1:0] levelFlat; // One level per source

  wire               winValid;
  wire [7:0]         winIrq;
  wire [2:0]         winLevel;

  // Bus phases
  wire access = psel & penable;
  wire done   = access & pready;
  wire wrDone = done & pwrite;

  // Address decode into register groups
  wire [11:0] flagOfs  = paddr - `ISVM_FLAG_BASE;
  wire [11:0] maskOfs  = paddr - `ISVM_MASK_BASE;
  wire [11:0] levelOfs = paddr - `ISVM_LEVEL_BASE;
  wire [9:0]  flagIdx  = flagOfs[11:2];
  wire [9:0]  maskIdx  = maskOfs[11:2];
  wire [9:0]  levelIdx = levelOfs[11:2];
  wire aligned  = (paddr[1:0] == 2'b00);
  wire inFlag   = aligned && paddr >= `ISVM_FLAG_BASE &&
                  flagIdx < `ISVM_NUM_FLAG_REGS;
  wire inMask   = aligned && paddr >= `ISVM_MASK_BASE &&
                  maskIdx < `ISVM_NUM_FLAG_REGS;
  wire inLevel  = aligned && paddr >= `ISVM_LEVEL_BASE &&
                  levelIdx < `ISVM_NUM_LEVEL_REGS;

  // four fields of three bits per word
  // flash fault keeps its own natural slot
  genvar k;
  generate
    for (k = 0; k < NUM_SRC; k = k + 1) begin : gField
      if (k < `ISVM_NUM_FIELDS) begin : gLive
        localparam integer POS = `ISVM_SRC_PER_REG * (k / 4) +
                                 `ISVM_FIELD_PITCH * (k % 4);
        assign levelFlat[k*3 +: 3]   = level_r[POS +: 3];
        assign levelWmask[POS +: 4]  = {1'b0, {3{implMask[k]}}};
      end else begin : gNone
        assign levelFlat[k*3 +: 3] = 3'h0;
      end
    end
  endgenerate

  // flag words: IRQ/16 selects word, IRQ%16 the bit
  // hardware event sets, software write loads the word (sets or clears)
  always @* begin
    flagNxt = flag_r;
    if (wrDone && inFlag) begin
      flagNxt[flagIdx*16 +: 16] = pwdata[15:0];
    end
    // Set wins over a clear in the same cycle
    flagNxt = (flagNxt | srcEvent) & implMask;
  end

  // mask words, same layout as flags
  always @* begin
    maskNxt = mask_r;
    if (wrDone && inMask) begin
      maskNxt[maskIdx*16 +: 16] = pwdata[15:0];
    end
    maskNxt = maskNxt & implMask;
  end

  always @* begin
    levelNxt = level_r;
    if (wrDone && inLevel) begin
      levelNxt[levelIdx*16 +: 16] = pwdata[15:0];
    end
    levelNxt = levelNxt & levelWmask;
  end

  // Block event status: set wins over clear
  always @* begin
    istatNxt = istat_r;
    if (wrDone && paddr == `ISVM_ICLR_ADDR) begin
      istatNxt = istatNxt & ~pwdata[1:0];
    end
    // New winner latched
    if (winValid && (!vstat_r[`ISVM_VVALID_BIT] ||
        vstat_r[7:0] != winIrq + `ISVM_VECTOR_OFFSET)) begin
      istatNxt[`ISVM_EV_WIN] = 1'b1;
    end
    // Event hit a flag that was still set
    if (|(srcEvent & flag_r & implMask)) begin
      istatNxt[`ISVM_EV_OVERRUN] = 1'b1;
    end
  end

  // Read mux and unmapped detection
  always @* begin
    rdNxt  = 32'h0000_0000;
    errNxt = 1'b0;
    if (inFlag) begin
      rdNxt[15:0] = flag_r[flagIdx*16 +: 16];
    end else if (inMask) begin
      rdNxt[15:0] = mask_r[maskIdx*16 +: 16];
    end else if (inLevel) begin
      rdNxt[15:0] = level_r[levelIdx*16 +: 16];
    end else if (paddr == `ISVM_VSTAT_ADDR) begin
      rdNxt[16:0] = vstat_r;
    end else if (paddr == `ISVM_ISTAT_ADDR) begin
      rdNxt[1:0] = istat_r;
    end else if (paddr == `ISVM_ICLR_ADDR) begin
      // Write-only, reads zero
      rdNxt = 32'h0000_0000;
    end else if (paddr == `ISVM_IEN_ADDR) begin
      rdNxt[1:0] = ien_r;
    end else begin
      errNxt = 1'b1;
    end
    // Status registers refuse writes
    if (pwrite && paddr == `ISVM_VSTAT_ADDR) begin
      errNxt = 1'b1;
    end
    if (pwrite && paddr == `ISVM_ISTAT_ADDR) begin
      errNxt = 1'b1;
    end
  end

  // APB slave: one wait state, answer registered
  always @(posedge mclk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= access & ~pready;
      prdata  <= (access & ~pready & ~pwrite) ? rdNxt : 32'h0000_0000;
      pslverr <= access & ~pready & errNxt;
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      flag_r  <= {FLAG_W{1'b0}};
      mask_r  <= {FLAG_W{1'b0}};
      level_r <= {LEVEL_W{1'b0}};
      istat_r <= 2'b00;
      ien_r   <= 2'b00;
    end else begin
      flag_r  <= flagNxt;
      mask_r  <= maskNxt;
      level_r <= levelNxt;
      istat_r <= istatNxt;
      if (wrDone && paddr == `ISVM_IEN_ADDR) begin
        ien_r <= pwdata[1:0];
      end
    end
  end

  isvm_arbiter #(
    .NUM_SRC (NUM_SRC)
  ) uArb (
    .mclk       (mclk),
    .rstn       (rstn),
    .pending    (flag_r & mask_r & implMask),
    .levels     (levelFlat),
    .winValid_r (winValid),
    .winIrq_r   (winIrq),
    .winLevel_r (winLevel)
  );

  always @(posedge mclk) begin
    if (!rstn) begin
      vstat_r        <= 17'h00000;
      cpuRequest_r   <= 1'b0;
      cpuVector_r    <= 8'h00;
      cpuLevel_r     <= 4'h0;
      cpuTableAddr_r <= 24'h000000;
      irqOut_r       <= 1'b0;
    end else begin
      cpuRequest_r <= winValid;
      irqOut_r     <= |(istatNxt & ien_r);
      if (winValid) begin
        vstat_r        <= {1'b1, 5'h00, winLevel,
                           winIrq + `ISVM_VECTOR_OFFSET};
        cpuVector_r    <= winIrq + `ISVM_VECTOR_OFFSET;
        cpuLevel_r     <= {1'b0, winLevel};
        cpuTableAddr_r <= `ISVM_TABLE_BASE + {15'h0000, winIrq, 1'b0};
      end else begin
        // Keep last vector, drop the valid mark
        vstat_r[`ISVM_VVALID_BIT] <= 1'b0;
      end
    end
  end

endmodule // isvm_vector_map

`default_nettype wire

// *** shared/isvm_consts.vh ***
/*
 * Constants of the interrupt source to vector map: register offsets,
 * field layouts, vector numbering and the table of implemented sources.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef ISVM_CONSTS_VH
`define ISVM_CONSTS_VH

// Register counts
`define ISVM_NUM_FLAG_REGS   12
`define ISVM_NUM_LEVEL_REGS  47
`define ISVM_NUM_SOURCES     192
`define ISVM_NUM_FIELDS      188

// Byte offsets on the register bus
`define ISVM_FLAG_BASE       12'h000
`define ISVM_MASK_BASE       12'h040
`define ISVM_LEVEL_BASE      12'h100
`define ISVM_VSTAT_ADDR      12'h200
`define ISVM_ISTAT_ADDR      12'h210
`define ISVM_ICLR_ADDR       12'h214
`define ISVM_IEN_ADDR        12'h218

// Field layout of the level registers
`define ISVM_FIELD_W         3
`define ISVM_FIELD_PITCH     4
`define ISVM_FIELDS_PER_REG  4
`define ISVM_SRC_PER_REG     16

// Winning vector status layout
`define ISVM_VNUM_LSB        0
`define ISVM_VLVL_LSB        8
`define ISVM_VVALID_BIT      16

// Vector numbering and table addressing
`define ISVM_VECTOR_OFFSET   8'h08
`define ISVM_TABLE_BASE      24'h000014

// Event bits of the block's own interrupt status
`define ISVM_EV_WIN          0
`define ISVM_EV_OVERRUN      1
`define ISVM_NUM_EVENTS      2

// Reset values
`define ISVM_RESET_WORD      16'h0000

// Implemented sources, one bit per IRQ, word 11 first
`define ISVM_IMPL_MASK {16'h07c0, 16'h2000, 16'h0000, 16'h4000, \
  16'h0000, 16'h0001, 16'hc000, 16'h2046, 16'h0200, 16'h007f, \
  16'hff1f, 16'hffff}

// Sources present only with the network controller
`define ISVM_NET_MASK {16'h0000, 16'h0000, 16'h0000, 16'h0000, \
  16'h0000, 16'h0000, 16'h0000, 16'h0040, 16'h0000, 16'h000c, \
  16'h0000, 16'h0000}

`endif

// *** verilog/isvm_arbiter.v ***
/*
 * Fixed-order arbiter: picks the pending source of highest level, the
 * lowest IRQ number among equals, and registers the result.
 * Assumes pending and level vectors come from logic on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module isvm_arbiter #(
  parameter NUM_SRC = 192
) (
  input  wire                   mclk,
  input  wire                   rstn,
  input  wire [NUM_SRC-1:0]     pending,
  input  wire [NUM_SRC*3-1:0]   levels,
  output reg                    winValid_r,
  output reg  [7:0]             winIrq_r,
  output reg  [2:0]             winLevel_r
);

  reg           found;     // Any candidate seen so far
  reg   [7:0]   bestIrq;   // Best IRQ so far
  reg   [2:0]   bestLvl;   // Best level so far
  integer       i;

  always @* begin
    found   = 1'b0;
    bestIrq = 8'h00;
    bestLvl = 3'h0;
    for (i = 0; i < NUM_SRC; i = i + 1) begin
      // Strictly greater replaces, so lower IRQ wins a tie
      if (pending[i] && (!found || levels[i*3 +: 3] > bestLvl)) begin
        found   = 1'b1;
        bestIrq = i[7:0];
        bestLvl = levels[i*3 +: 3];
      end
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      winValid_r <= 1'b0;
      winIrq_r   <= 8'h00;
      winLevel_r <= 3'h0;
    end else begin
      winValid_r <= found;
      winIrq_r   <= bestIrq;
      winLevel_r <= bestLvl;
    end
  end

endmodule // isvm_arbiter

`default_nettype wire

// *** dv/isvm_vector_map_monitor.sv ***
/* Checker for the source-to-vector map: bus timing and the winning
   vector outputs. Assumes it is bound to the top module's ports. */
`timescale 1ns/1ps
`default_nettype none
module isvm_vector_map_monitor (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cpuRequest_r,
  input wire logic [7:0]  cpuVector_r,
  input wire logic [3:0]  cpuLevel_r,
  input wire logic [23:0] cpuTableAddr_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_ready_wait: assert property (
    psel && !penable |=> !pready ##1 pready)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("ready held too long");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  chk_ro_refuse: assert property (
    pready && pwrite && paddr == 12'h200 |-> pslverr)
    else $error("status write not refused");
  chk_rdata_idle: assert property (
    !pready |-> prdata == 32'h0) else $error("read data outside reply");
  chk_rst_clear: assert property (
    $rose(rstn) |-> !cpuRequest_r && !pready && cpuVector_r == 8'h00)
    else $error("outputs not clear after reset");
  chk_vec_range: assert property (
    cpuRequest_r |-> cpuVector_r >= 8'h08 && cpuVector_r <= 8'hc2)
    else $error("vector out of range");
  chk_table_addr: assert property (
    cpuRequest_r |-> cpuTableAddr_r ==
      24'h000014 + {15'h0, cpuVector_r - 8'h08, 1'b0})
    else $error("table address off its vector");
  chk_level_top: assert property (
    cpuRequest_r |-> cpuLevel_r[3] == 1'b0)
    else $error("level top bit set");
endmodule // isvm_vector_map_monitor
bind isvm_vector_map isvm_vector_map_monitor u_mon (.mclk, .rstn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .cpuRequest_r, .cpuVector_r, .cpuLevel_r, .cpuTableAddr_r);
`default_nettype wire

// *** dv/isvm_source_model.sv ***
/* Peripheral side model: a fire request becomes a one-cycle event on
   the chosen IRQ line. Assumes requests change just after mclk. */
`timescale 1ns/1ps
`default_nettype none
module isvm_source_model (
  input  wire logic         mclk,
  input  wire logic         fire,
  input  wire logic [7:0]   irq,
  output var  logic [191:0] srcEvent
);
  // Quiet until the first request
  initial srcEvent = 192'h0;
  always @(posedge mclk) begin
    srcEvent <= fire ? (192'h1 << irq) : 192'h0;
  end
endmodule // isvm_source_model
`default_nettype wire

// *** dv/isvm_vector_map_tb.sv ***
/* Testbench of the source-to-vector map: APB register tests and event
   tests. Assumes the monitor binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
module isvm_vector_map_tb;
  logic        mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, fire = 0;
  logic        cpuRequest_r, irqOut_r;
  logic [7:0]  irq = 8'h00, cpuVector_r;
  logic [3:0]  cpuLevel_r;
  logic [23:0] cpuTableAddr_r;
  logic [191:0] srcEvent;
  logic [31:0] prdata0, rdat0;
  int mismatches = 0, checkCount = 0, k;
  int ids[16] = '{0,4,14,15,24,34,36,65,66,94,95,96,182,184,185,186};
  int rsv[4] = '{46, 61, 72, 187};
  int vids[6] = '{0, 10, 24, 65, 94, 186};
  isvm_vector_map dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .srcEvent, .cpuRequest_r,
    .cpuVector_r, .cpuLevel_r, .cpuTableAddr_r, .irqOut_r);
  // Variant without the network sources, same stimulus
  isvm_vector_map #(.HAS_NETWORK(0)) dut_lite (.mclk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata(prdata0), .pready(),
    .pslverr(), .srcEvent, .cpuRequest_r(), .cpuVector_r(),
    .cpuLevel_r(), .cpuTableAddr_r(), .irqOut_r());
  isvm_source_model u_src (.mclk, .fire, .irq, .srcEvent);
  // Clock of 5 ns
  always #2.5 mclk = ~mclk;
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, waits for ready
  task automatic xfer(input logic w, input int a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a[11:0];
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    rdat0 = prdata0;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Event pulse from the source model
  task automatic pulse(input int n);
    fire <= 1'b1;
    irq <= n[7:0];
    @(posedge mclk);
    fire <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    xfer(0, 12'h000, 0);
    check(rdat, 32'h0);
    xfer(0, 12'h200, 0);
    check(rdat, 32'h0);
    $display("reset test done");
    foreach (ids[i]) begin
      pulse(ids[i]);
      xfer(0, ids[i] / 16 * 4, 0);
      check(rdat, 32'h1 << (ids[i] % 16));
      check(rdat0, ids[i] == 34 ? 32'h0 : 32'h1 << (ids[i] % 16));
      xfer(1, ids[i] / 16 * 4, 0);
    end
    foreach (rsv[i]) begin
      xfer(1, 12'h040 + rsv[i] / 16 * 4, 32'hffff);
      pulse(rsv[i]);
      xfer(0, rsv[i] / 16 * 4, 0);
      check(rdat, 32'h0);
      check(cpuRequest_r, 32'h0);
      xfer(1, 12'h040 + rsv[i] / 16 * 4, 0);
    end
    $display("placement test done");
    foreach (vids[i]) begin
      k = vids[i];
      xfer(1, 12'h040 + k / 16 * 4, 32'h1 << (k % 16));
      xfer(1, 12'h100 + k / 4 * 4, 32'h5 << (k % 4 * 4));
      pulse(k);
      check(cpuVector_r, k + 8);
      check(cpuTableAddr_r, 32'h14 + 2 * k);
      check({cpuRequest_r, cpuLevel_r}, 32'h15);
      xfer(0, 12'h200, 0);
      check(rdat, 32'h10500 + k + 8);
      xfer(1, k / 16 * 4, 0);
    end
    $display("vector test done");
    // ties and levels, software set
    // Both IRQ 0 and IRQ 10 enabled at equal level
    xfer(1, 12'h040, 32'h0401);
    xfer(1, 12'h000, 32'h0401);
    repeat (4) @(posedge mclk);
    check(cpuVector_r, 32'h08);
    xfer(1, 12'h108, 32'h0700);
    repeat (4) @(posedge mclk);
    check({cpuLevel_r, cpuVector_r}, 32'h712);
    xfer(1, 12'h100, 32'h0007);
    repeat (4) @(posedge mclk);
    check(cpuVector_r, 32'h08);
    xfer(1, 12'h040, 0);
    repeat (4) @(posedge mclk);
    check(cpuRequest_r, 32'h0);
    xfer(0, 12'h000, 0);
    check(rdat, 32'h0401);
    $display("arbitration test done");
    // Block interrupt raise, mask, clear
    xfer(1, 12'h214, 32'h3);
    xfer(1, 12'h218, 32'h1);
    xfer(1, 12'h040, 32'h1);
    pulse(0);
    xfer(0, 12'h210, 0);
    check({irqOut_r, rdat[30:0]}, 32'h80000003);
    xfer(1, 12'h218, 0);
    repeat (3) @(posedge mclk);
    check(irqOut_r, 32'h0);
    xfer(1, 12'h214, 32'h3);
    xfer(0, 12'h210, 0);
    check(rdat, 32'h0);
    xfer(0, 12'hffc, 0);
    check(rerr, 32'h1);
    xfer(1, 12'h200, 32'h5);
    check(rerr, 32'h1);
    xfer(0, 12'h214, 0);
    check({rerr, rdat[30:0]}, 32'h0);
    $display("interrupt test done");
    // reset in mid-run clears flags, levels, request
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    xfer(0, 12'h000, 0);
    check(rdat, 32'h0);
    xfer(0, 12'h100, 0);
    check(rdat, 32'h0);
    check(cpuRequest_r, 32'h0);
    $display("mid-run reset test done");
    test_done;
  end
endmodule // isvm_vector_map_tb
`default_nettype wire
